// ===== rtf_pkg.sv
package rtf_pkg;
	// Rate figures in kHz, as printed
	localparam int CHIP_RATE_KHZ = 499200;
	localparam int SUBCHIP_DIVISOR = 128;
	localparam int CLOCK_RATE_KHZ = 10000;
	// Counter counts per clock: whole part plus a remainder modulo the clock rate
	localparam int COUNT_RATE_PRODUCT = CHIP_RATE_KHZ * SUBCHIP_DIVISOR;
	localparam int STEP_WHOLE = COUNT_RATE_PRODUCT / CLOCK_RATE_KHZ;
	localparam int STEP_REMAINDER = COUNT_RATE_PRODUCT % CLOCK_RATE_KHZ;

	localparam int COUNTER_WIDTH = 32;
	localparam int INTERVAL_WIDTH = 32;
	localparam int MAGNITUDE_WIDTH = 19;
	localparam int OFFSET_FIELD_WIDTH = 24;
	localparam int SIGN_POSITION = 19;

	// Figure-of-merit layout and special values
	localparam int FOM_EXTENSION_BIT = 7;
	localparam int FOM_SCALE_LSB = 5;
	localparam int FOM_INTERVAL_LSB = 3;
	localparam int FOM_LEVEL_LSB = 0;
	localparam logic [7:0] FOM_NO_INFO = 8'h00;
	localparam logic [7:0] FOM_UNCORRECTED = 8'h80;
	localparam logic [2:0] LEVEL_LOWEST = 3'h1;

	// Register byte offsets
	localparam logic [7:0] OFFSET_CONTROL = 8'h00;
	localparam logic [7:0] OFFSET_STATUS = 8'h04;
	localparam logic [7:0] OFFSET_NOW = 8'h08;
	localparam logic [7:0] OFFSET_START = 8'h0C;
	localparam logic [7:0] OFFSET_STOP = 8'h10;
	localparam logic [7:0] OFFSET_INTERVAL = 8'h14;
	localparam logic [7:0] OFFSET_TRACK = 8'h18;
	localparam logic [7:0] OFFSET_FOM = 8'h1C;

	// Control and status bit positions, reset values
	localparam int CONTROL_RUN_BIT = 0;
	localparam int CONTROL_CHAR_BIT = 1;
	localparam logic [1:0] CONTROL_RESET = 2'h3;
	localparam int STATUS_MEASURE_BIT = 0;
	localparam int STATUS_PENDING_BIT = 1;
	localparam int STATUS_DROPPED_BIT = 2;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		RTF_IDLE = 2'b00,
		RTF_MEASURE = 2'b01,
		RTF_REPORT = 2'b10
	} rtf_state_type;
endpackage

// ===== rtf_fom_if.sv
`timescale 1ns/1ps
interface rtf_fom_if;
	logic capture; // Take a new quality snapshot
	logic known; // Quality information exists
	logic untrusted; // Measurement cannot be trusted
	logic uncorrected; // Start count not corrected
	logic [2:0] level; // Confidence level code
	logic [1:0] interval; // Confidence interval code
	logic [1:0] scale; // Interval scaling code
	logic [7:0] octet; // Encoded figure of merit
	modport encoder (input capture, known, untrusted, uncorrected, level, interval, scale,
		output octet);
	modport user (output capture, known, untrusted, uncorrected, level, interval, scale,
		input octet);
endinterface

// ===== rtf_fom_encoder.sv
`timescale 1ns/1ps
module rtf_fom_encoder
	import rtf_pkg::*;
(
	input wire logic clock, // System clock
	input wire logic reset_n, // Synchronous reset, active low
	rtf_fom_if.encoder fom // Quality fields in, octet out
);
	logic [7:0] normal_octet;
	logic [2:0] safe_level;
	logic [7:0] next_octet;

	// A known quality never encodes as level zero, that code means no information
	assign safe_level = (fom.level == 3'h0) ? LEVEL_LOWEST : fom.level;
	assign normal_octet = (8'(fom.scale) << FOM_SCALE_LSB)
		| (8'(fom.interval) << FOM_INTERVAL_LSB)
		| (8'(safe_level) << FOM_LEVEL_LSB);

	// Priority: uncorrected start, then no information, then worst or given quality
	assign next_octet = fom.uncorrected ? FOM_UNCORRECTED :
		!fom.known ? FOM_NO_INFO :
		fom.untrusted ? {1'b0, 2'h3, 2'h3, LEVEL_LOWEST} :
		normal_octet;

	// Held from the start capture until the next one
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			fom.octet <= FOM_NO_INFO;
		end else if (fom.capture) begin
			fom.octet <= next_octet;
		end
	end
endmodule

// ===== rtf_ranging.sv
// Contract
// - Counter values are 32-bit unsigned
// - Counter LSB is chip period over 128
// - Characterization yields offset and interval each report
// - Tracking window spans start to stop
// - Offset is sign-magnitude, 19-bit magnitude
// - Sign clear when transmitter oscillator faster
// - Offset over interval gives frequency difference
// - Interval is 32-bit, same unit
// - Tracking unit no longer than one chip
// - One figure of merit per counter value
// - Octet: extension, scale, interval, level fields
// - Level codes map to confidence percentages
// - Interval codes give full widths
// - Scale codes multiply by half to four
// - Extension set: only 0x80, uncorrected start
// - Zero only when no information; worst 0x79
// - Figure describes the reported start pulse
// - Report has five fields of fixed sizes
// - Five values always delivered together
`timescale 1ns/1ps
module rtf_ranging
	import rtf_pkg::*;
#(
	parameter bit CHAR_PRESENT = 1'b1 // Oscillator characterization built in
)(
	input wire logic clock, // 10 MHz system clock
	input wire logic reset_n, // Synchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic start_pulse, // First header pulse arrived
	input wire logic stop_pulse, // Measurement end reached
	input wire logic drift_step, // One part of oscillator slip seen
	input wire logic drift_tx_faster, // Slip direction: transmitter faster
	input wire logic quality_known, // Quality information exists
	input wire logic quality_untrusted, // Measurement untrustworthy
	input wire logic uncorrected_start_flag, // Start count uncorrected
	input wire logic [2:0] quality_level, // Confidence level code
	input wire logic [1:0] quality_interval, // Confidence interval code
	input wire logic [1:0] quality_scale, // Interval scaling code
	output logic report_valid, // Timestamp report offered
	input wire logic report_ready, // MAC takes the report
	output logic [31:0] report_start, // Counter start value
	output logic [31:0] report_stop, // Counter stop value
	output logic [31:0] report_interval, // Tracking interval
	output logic [23:0] report_offset, // Tracking offset field
	output logic [7:0] figure_of_merit // Figure of merit octet
);
	localparam int FRACTION_WIDTH = $clog2(CLOCK_RATE_KHZ + 1);
	localparam int DRIFT_WIDTH = MAGNITUDE_WIDTH + 2;

	rtf_fom_if fom_bus ();

	rtf_state_type state;
	rtf_state_type next_state;
	logic [COUNTER_WIDTH-1:0] counter_now;
	logic [FRACTION_WIDTH-1:0] fraction;
	logic [1:0] control;
	logic dropped;
	logic [COUNTER_WIDTH-1:0] counter_start_value;
	logic signed [DRIFT_WIDTH-1:0] drift;
	logic [7:0] write_addr;
	logic write_addr_full;
	logic [31:0] write_data;
	logic [3:0] write_strobe;
	logic write_data_full;

	// Fractional step: add the whole part every clock plus a carry from the remainder
	wire [FRACTION_WIDTH:0] fraction_sum = {1'b0, fraction}
		+ (FRACTION_WIDTH + 1)'(STEP_REMAINDER);
	wire fraction_carry = fraction_sum >= (FRACTION_WIDTH + 1)'(CLOCK_RATE_KHZ);
	wire [FRACTION_WIDTH-1:0] next_fraction = fraction_carry
		? FRACTION_WIDTH'(fraction_sum - (FRACTION_WIDTH + 1)'(CLOCK_RATE_KHZ))
		: FRACTION_WIDTH'(fraction_sum);
	wire [COUNTER_WIDTH-1:0] counter_step = COUNTER_WIDTH'(STEP_WHOLE)
		+ COUNTER_WIDTH'(fraction_carry);
	wire run_enable = control[CONTROL_RUN_BIT];
	wire char_enable = CHAR_PRESENT && control[CONTROL_CHAR_BIT];

	// Sequencing events
	wire take_start = (state == RTF_IDLE) && start_pulse && run_enable;
	wire take_stop = (state == RTF_MEASURE) && stop_pulse;
	wire report_taken = report_valid && report_ready;
	wire start_lost = start_pulse && (state == RTF_REPORT);

	// Offset magnitude and sign from the signed slip count
	wire drift_negative = drift[DRIFT_WIDTH-1];
	wire [DRIFT_WIDTH-1:0] drift_abs = drift_negative ? DRIFT_WIDTH'(-drift)
		: DRIFT_WIDTH'(drift);
	wire magnitude_over = |drift_abs[DRIFT_WIDTH-1:MAGNITUDE_WIDTH];
	wire [MAGNITUDE_WIDTH-1:0] magnitude = magnitude_over ? {MAGNITUDE_WIDTH{1'b1}}
		: drift_abs[MAGNITUDE_WIDTH-1:0];
	wire [OFFSET_FIELD_WIDTH-1:0] offset_field = {
		{(OFFSET_FIELD_WIDTH - MAGNITUDE_WIDTH - 1){1'b0}},
		drift_negative, magnitude};
	// Interval in counter counts, a part of 1/128 chip
	wire [INTERVAL_WIDTH-1:0] interval_parts = counter_now - counter_start_value;

	// Counter, free running while enabled
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			counter_now <= '0;
			fraction <= '0;
		end else if (run_enable) begin
			counter_now <= counter_now + counter_step;
			fraction <= next_fraction;
		end
	end

	// State sequencing
	always_comb begin
		next_state = state;
		unique case (state)
			RTF_IDLE: begin
				if (take_start) begin
					next_state = RTF_MEASURE;
				end
			end
			RTF_MEASURE: begin
				if (take_stop) begin
					next_state = RTF_REPORT;
				end
			end
			RTF_REPORT: begin
				if (report_taken) begin
					next_state = RTF_IDLE;
				end
			end
			default: begin
				next_state = RTF_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state <= RTF_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Start capture; the figure of merit is captured on the same edge
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			counter_start_value <= '0;
		end else if (take_start) begin
			counter_start_value <= counter_now;
		end
	end

	assign fom_bus.capture = take_start;
	assign fom_bus.known = quality_known;
	assign fom_bus.untrusted = quality_untrusted;
	assign fom_bus.uncorrected = uncorrected_start_flag;
	assign fom_bus.level = quality_level;
	assign fom_bus.interval = quality_interval;
	assign fom_bus.scale = quality_scale;

	rtf_fom_encoder fom_encoder (
		.clock(clock),
		.reset_n(reset_n),
		.fom(fom_bus.encoder)
	);

	// Slip count runs from start to stop, so the window covers the whole span
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			drift <= '0;
		end else if (take_start) begin
			drift <= '0;
		end else if (state == RTF_MEASURE && drift_step) begin
			drift <= drift_tx_faster ? drift + DRIFT_WIDTH'(1)
				: drift - DRIFT_WIDTH'(1);
		end
	end

	// One snapshot of all five values; held until the MAC takes it
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			report_start <= '0;
			report_stop <= '0;
			report_interval <= '0;
			report_offset <= '0;
			figure_of_merit <= FOM_NO_INFO;
		end else if (take_stop) begin
			report_start <= counter_start_value;
			report_stop <= counter_now;
			report_interval <= char_enable ? interval_parts : '0;
			report_offset <= char_enable ? offset_field : '0;
			figure_of_merit <= fom_bus.octet;
		end
	end

	// Valid only after the snapshot edge, so no field lags another
	assign report_valid = (state == RTF_REPORT);

	// Sticky drop flag: a start lost while a report waits; set beats clear
	wire control_write = write_addr_full && write_data_full && !s_axi_bvalid;
	wire addr_is_control = write_addr == OFFSET_CONTROL;
	wire drop_clear = control_write && addr_is_control && write_strobe[0]
		&& write_data[STATUS_DROPPED_BIT];
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			dropped <= 1'b0;
		end else if (start_lost) begin
			dropped <= 1'b1;
		end else if (drop_clear) begin
			dropped <= 1'b0;
		end
	end

	// Write channel: address and data taken in either order
	assign s_axi_awready = !write_addr_full && !s_axi_bvalid;
	assign s_axi_wready = !write_data_full && !s_axi_bvalid;
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			write_addr_full <= 1'b0;
			write_addr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			write_addr_full <= 1'b1;
			write_addr <= s_axi_awaddr;
		end else if (control_write) begin
			write_addr_full <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			write_data_full <= 1'b0;
			write_data <= '0;
			write_strobe <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			write_data_full <= 1'b1;
			write_data <= s_axi_wdata;
			write_strobe <= s_axi_wstrb;
		end else if (control_write) begin
			write_data_full <= 1'b0;
		end
	end

	// Only the control word is writable; other mapped words ignore writes
	wire write_mapped = (write_addr[7:2] <= OFFSET_FOM[7:2]) && (write_addr[1:0] == 2'h0);
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			control <= CONTROL_RESET;
		end else if (control_write && addr_is_control && write_strobe[0]) begin
			control <= write_data[1:0];
		end
	end

	// Response one cycle after both halves are held
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (control_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= write_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read decode; status shows the sequencer, pending report and drop flag
	logic [31:0] read_word;
	logic read_hit;
	wire [31:0] status_word = {29'h0, dropped, report_valid, state == RTF_MEASURE};
	always_comb begin
		read_hit = 1'b1;
		unique case (s_axi_araddr)
			OFFSET_CONTROL: read_word = {30'h0, control};
			OFFSET_STATUS: read_word = status_word;
			OFFSET_NOW: read_word = counter_now;
			OFFSET_START: read_word = report_start;
			OFFSET_STOP: read_word = report_stop;
			OFFSET_INTERVAL: read_word = report_interval;
			OFFSET_TRACK: read_word = {8'h0, report_offset};
			OFFSET_FOM: read_word = {24'h0, figure_of_merit};
			default: begin
				read_word = 32'h0;
				read_hit = 1'b0;
			end
		endcase
	end

	// Read channel: one read in flight, data from a register
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= read_word;
			s_axi_rresp <= read_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// ===== rtf_mac_model.sv
`timescale 1ns/1ps
module rtf_mac_model (
	input wire logic clock, // System clock
	input wire logic reset_n, // Reset, active low
	input wire logic [7:0] stall, // Cycles before accepting
	input wire logic report_valid, // Report offered
	input wire logic [127:0] report_data, // All five fields, 16 octets
	output logic report_ready, // Report accepted
	output logic [127:0] got_report, // Last report taken
	output logic [7:0] got_count // Reports taken
);
	logic [7:0] wait_count;
	// Stalls so the device must hold a report; latches every field at one edge
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			wait_count <= 8'h00;
			got_count <= 8'h00;
			got_report <= '0;
		end else if (report_valid && report_ready) begin
			got_report <= report_data;
			got_count <= got_count + 8'h01;
			wait_count <= 8'h00;
		end else if (report_valid) begin
			wait_count <= wait_count + 8'h01;
		end
	end
	assign report_ready = report_valid && wait_count >= stall;
endmodule

// ===== rtf_properties.sv
`timescale 1ns/1ps
module rtf_properties (
	input wire logic clock, // Clock
	input wire logic reset_n, // Reset
	input wire logic s_axi_arvalid, // Read request
	input wire logic s_axi_rvalid, // Read answer
	input wire logic stop_pulse, // Measurement end
	input wire logic report_valid, // Report offered
	input wire logic report_ready, // Report taken
	input wire logic [31:0] report_start, // Start value
	input wire logic [31:0] report_stop, // Stop value
	input wire logic [31:0] report_interval, // Interval
	input wire logic [23:0] report_offset, // Offset field
	input wire logic [7:0] figure_of_merit // Quality octet
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	property p_hold;
		report_valid && !report_ready |=> report_valid && $stable({report_start, report_stop,
			report_interval, report_offset, figure_of_merit});
	endproperty
	a_hold: assert property (p_hold) else $error("report changed while held");
	property p_take;
		report_valid && report_ready |=> !report_valid;
	endproperty
	a_take: assert property (p_take) else $error("report stays after take");
	property p_load;
		$rose(report_valid) |-> $past(stop_pulse);
	endproperty
	a_load: assert property (p_load) else $error("report without stop");
	property p_pad;
		report_valid |-> report_offset[23:20] == 4'h0;
	endproperty
	a_pad: assert property (p_pad) else $error("offset upper bits set");
	property p_ext;
		report_valid && figure_of_merit[7] |-> figure_of_merit == 8'h80;
	endproperty
	a_ext: assert property (p_ext) else $error("reserved extension value");
	property p_lvl;
		report_valid && figure_of_merit != 8'h00 && !figure_of_merit[7] |->
			figure_of_merit[2:0] != 3'h0;
	endproperty
	a_lvl: assert property (p_lvl) else $error("quality with empty level");
	property p_win;
		report_valid && report_interval != 32'h0 |-> report_interval == report_stop - report_start;
	endproperty
	a_win: assert property (p_win) else $error("interval not stop minus start");
	property p_rans;
		s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid;
	endproperty
	a_rans: assert property (p_rans) else $error("read not answered");
endmodule
bind rtf_ranging rtf_properties rtf_properties_inst (.clock, .reset_n, .s_axi_arvalid,
	.s_axi_rvalid, .stop_pulse, .report_valid, .report_ready, .report_start, .report_stop,
	.report_interval, .report_offset, .figure_of_merit);

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
	import rtf_pkg::*;
	logic clock, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, figure_of_merit, stall, got_count;
	logic [31:0] s_axi_wdata, s_axi_rdata, report_start, report_stop, report_interval, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, quality_interval, quality_scale, rs;
	logic start_pulse, stop_pulse, drift_step, drift_tx_faster, quality_known;
	logic quality_untrusted, uncorrected_start_flag, report_valid, report_ready;
	logic [2:0] quality_level;
	logic [23:0] report_offset;
	logic [127:0] got_report;
	int fail_count, n_checks;
	rtf_ranging rtf_ranging_inst (.clock, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .start_pulse, .stop_pulse,
		.drift_step, .drift_tx_faster, .quality_known, .quality_untrusted,
		.uncorrected_start_flag, .quality_level, .quality_interval, .quality_scale,
		.report_valid, .report_ready, .report_start, .report_stop, .report_interval,
		.report_offset, .figure_of_merit);
	rtf_mac_model rtf_mac_model_inst (.clock, .reset_n, .stall, .report_valid,
		.report_data({report_start, report_stop, report_interval, report_offset,
		figure_of_merit}), .report_ready, .got_report, .got_count);
	// Free-running bench clock, 100 ns
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Both halves offered together; each dropped at the edge it is taken
	task axi_wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clock);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) begin
				rs = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
		if (i == 50) begin
			cmp("write wait", 1, 0);
			finish_test;
		end
	endtask
	task rd_chk(input string name, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int i;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clock);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				rd = s_axi_rdata;
				rs = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
		if (i == 50) begin
			cmp("read wait", 1, 0);
			finish_test;
		end
		cmp(name, d, rd);
		cmp("read response", r, rs);
	endtask
	// Expected octet: q is {uncorrected, untrusted, known, scale, interval, level}
	function logic [7:0] fom_of(input logic [9:0] q);
		if (q[9])
			return 8'h80;
		if (!q[7])
			return 8'h00;
		if (q[8])
			return 8'h79;
		return {1'b0, q[6:3], q[2:0] == 3'h0 ? 3'h1 : q[2:0]};
	endfunction
	// Quality inputs change after start, so a late capture shows up
	task measure(input int nd, input logic dir, input logic [9:0] q, input logic extra,
		input logic char_on);
		logic [7:0] n0;
		logic [31:0] s, p, iv;
		logic [23:0] of;
		logic [7:0] fm;
		int j, k;
		n0 = got_count;
		k = 2 * nd + 2;
		for (j = 0; j <= k + 2; j++) begin
			@(posedge clock);
			start_pulse <= j == 0 || (extra && j == k + 1);
			stop_pulse <= j == k;
			drift_step <= j % 2 == 1 && j < 2 * nd;
			drift_tx_faster <= dir;
			{uncorrected_start_flag, quality_untrusted, quality_known, quality_scale,
				quality_interval, quality_level} <= j == 0 ? q : 10'h000;
		end
		for (j = 0; j < 100 && got_count == n0; j++)
			@(posedge clock);
		if (got_count == n0) begin
			cmp("report wait", 1, 0);
			finish_test;
		end
		{s, p, iv, of, fm} = got_report;
		cmp("fom", fom_of(q), fm);
		cmp("offset", char_on ? {4'h0, !dir && nd != 0, 19'(nd)} : 0, of);
		cmp("interval", char_on ? p - s : 0, iv);
		cmp("rate", 1, p - s >= k * STEP_WHOLE && p - s <= k * (STEP_WHOLE + 1));
		rd_chk("fom register", OFFSET_FOM, {24'h0, fom_of(q)}, RESP_OKAY);
	endtask
	task test_regs;
		cmp("reset fom", 8'h00, figure_of_merit);
		rd_chk("control", OFFSET_CONTROL, 32'h3, RESP_OKAY);
		rd_chk("status", OFFSET_STATUS, 32'h0, RESP_OKAY);
		rd_chk("unmapped", 8'h20, 32'h0, RESP_SLVERR);
		axi_wr(8'h24, 32'h0);
		cmp("unmapped write", RESP_SLVERR, rs);
	endtask
	task test_codes;
		for (int i = 0; i < 8; i++)
			measure(0, 1'b0, {3'b001, 2'(i), 2'(i + 1), 3'(i)}, 1'b0, 1'b1);
		measure(1, 1'b1, 10'h200, 1'b0, 1'b1);
		measure(1, 1'b1, 10'h000, 1'b0, 1'b1);
		measure(1, 1'b1, 10'h187, 1'b0, 1'b1);
	endtask
	task test_drift;
		measure(3, 1'b1, 10'h0BD, 1'b0, 1'b1);
		measure(5, 1'b0, 10'h0BD, 1'b0, 1'b1);
	endtask
	// Second start while the MAC stalls must be dropped and flagged
	task test_dropped;
		@(posedge clock);
		stall <= 8'h0A;
		measure(2, 1'b1, 10'h0AA, 1'b1, 1'b1);
		rd_chk("dropped", OFFSET_STATUS, 32'h4, RESP_OKAY);
		axi_wr(OFFSET_CONTROL, 32'h7);
		rd_chk("cleared", OFFSET_STATUS, 32'h0, RESP_OKAY);
		stall <= 8'h00;
	endtask
	task test_char_off;
		axi_wr(OFFSET_CONTROL, 32'h1);
		rd_chk("control off", OFFSET_CONTROL, 32'h1, RESP_OKAY);
		measure(2, 1'b0, 10'h0BD, 1'b0, 1'b0);
		axi_wr(OFFSET_CONTROL, 32'h3);
	endtask
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, stall, s_axi_wdata} = 56'h0;
		s_axi_wstrb = 4'hF;
		{start_pulse, stop_pulse, drift_step, drift_tx_faster} = 4'h0;
		{uncorrected_start_flag, quality_untrusted, quality_known} = 3'h0;
		{quality_level, quality_interval, quality_scale} = 7'h00;
		fail_count = 0;
		n_checks = 0;
		reset_n = 1'b0;
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		test_regs();
		test_codes();
		test_drift();
		test_dropped();
		test_char_off();
		finish_test();
	end
endmodule
